// >>> hw/rcd_decoder.sv
// receiver command decoder with apb register access
`timescale 1ns/10ps
module rcd_decoder (
    input wire logic core_clk, // 125 MHz clock
    input wire logic rst, // async reset, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    output logic pass_start, // one-cycle pass start pulse
    output rcd_pkg::rcd_pass_t pass_kind, // kind of pass started
    output logic [4:0] band_select, // bands of the pass
    output logic high_band_two_sel // fast pass uses band two
);
    import rcd_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0] abc_mode_reg, abc_mode_next; // ext[15:8] mode[7:0]
    logic [15:0] hb1_mode_reg, hb1_mode_next;
    logic [15:0] hb2_mode_reg, hb2_mode_next;
    logic [8:0] abc_rep_reg, abc_rep_next;
    logic [8:0] hb1_rep_reg, hb1_rep_next;
    logic [8:0] hb2_rep_reg, hb2_rep_next;
    logic [8:0] hb1_start_reg, hb1_start_next; // 25 kHz units
    logic [8:0] hb1_step_reg, hb1_step_next;
    logic [8:0] hb1_count_reg, hb1_count_next;
    logic [8:0] hb2_start_reg, hb2_start_next; // 50 kHz units
    logic [8:0] hb2_step_reg, hb2_step_next;
    logic [8:0] hb2_count_reg, hb2_count_next;
    logic [8:0] cycle_cnt_reg, cycle_cnt_next;
    logic [7:0] fpga_word_reg [0:7];
    logic [7:0] fpga_word_next [0:7];
    logic [1:0] synth_sel_reg, synth_sel_next; // 0 auto 1 low 2 high
    logic [1:0] compress_reg, compress_next; // 0 none 1 meander 2 rice
    logic [6:0] mfr_ant_reg, mfr_ant_next; // cal and antenna bits
    logic [7:0] limit_relay_reg, limit_relay_next;
    logic [7:0] atten_reg, atten_next;
    logic [2:0] reinit_reg, reinit_next; // fpga, modes, coef pulses
    logic [7:0] snd_mode_reg, snd_mode_next;
    logic [7:0] fast_a_reg, fast_a_next; // fast parameters A
    logic [7:0] fast_b_reg, fast_b_next; // fast parameters B
    logic [7:0] version_reg, version_next;
    logic [7:0] blk_len_reg, blk_len_next; // signed byte count
    logic blk_drop_reg, blk_drop_next;
    logic [15:0] last_cmd_reg, last_cmd_next;
    logic [31:0] prdata_next;
    logic pass_start_next;
    rcd_pass_t pass_kind_next;
    logic [4:0] band_select_next;
    logic hb2_sel_next;

    logic [2:0] cmd_class;
    logic [3:0] cmd_sub4, cmd_sub_nib;
    logic [8:0] cmd_arg9;
    logic [7:0] cmd_arg8;
    logic wr_en, rd_en, cmd_wr, cmd_ok;

    // field split of the incoming command word
    rcd_field_decode u_fields (
        .cmd_word(pwdata[15:0]),
        .cmd_class(cmd_class),
        .cmd_sub4(cmd_sub4),
        .cmd_sub_nib(cmd_sub_nib),
        .cmd_arg9(cmd_arg9),
        .cmd_arg8(cmd_arg8)
    );

    // ------------------------------------------------------------
    // apb access, always zero wait states
    // ------------------------------------------------------------
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign cmd_wr = wr_en && (paddr == RCD_CMD_OFS);
    // once a word would push a block past 127 bytes, every later word is swallowed
    assign cmd_ok = cmd_wr && !blk_drop_reg;

    // command decode and register next values
    always_comb begin
        abc_mode_next = abc_mode_reg;
        hb1_mode_next = hb1_mode_reg;
        hb2_mode_next = hb2_mode_reg;
        abc_rep_next = abc_rep_reg;
        hb1_rep_next = hb1_rep_reg;
        hb2_rep_next = hb2_rep_reg;
        hb1_start_next = hb1_start_reg;
        hb1_step_next = hb1_step_reg;
        hb1_count_next = hb1_count_reg;
        hb2_start_next = hb2_start_reg;
        hb2_step_next = hb2_step_reg;
        hb2_count_next = hb2_count_reg;
        cycle_cnt_next = cycle_cnt_reg;
        fpga_word_next = fpga_word_reg;
        synth_sel_next = synth_sel_reg;
        compress_next = compress_reg;
        mfr_ant_next = mfr_ant_reg;
        limit_relay_next = limit_relay_reg;
        atten_next = atten_reg;
        reinit_next = 3'h0;
        snd_mode_next = snd_mode_reg;
        fast_a_next = fast_a_reg;
        fast_b_next = fast_b_reg;
        version_next = version_reg;
        blk_len_next = blk_len_reg;
        blk_drop_next = blk_drop_reg;
        last_cmd_next = last_cmd_reg;
        pass_start_next = 1'b0;
        pass_kind_next = pass_kind;
        band_select_next = band_select;
        hb2_sel_next = high_band_two_sel;
        // two bytes per word; signed count overflow marks the block
        if (cmd_wr && !blk_drop_reg) begin
            if (blk_len_reg > RCD_BLK_MAX - 8'h02) begin
                blk_drop_next = 1'b1;
            end else begin
                blk_len_next = blk_len_reg + 8'h02;
            end
        end
        if (cmd_ok && blk_len_reg <= RCD_BLK_MAX - 8'h02) begin
            last_cmd_next = pwdata[15:0];
            unique case (cmd_class)
                RCD_CLS_ANAL: begin
                    if (!cmd_sub4[3] && cmd_sub_nib == 4'h0) begin
                        pass_start_next = 1'b1;
                        if (cmd_arg8[RCD_FAST_BIT]) begin
                            pass_kind_next = RCD_PASS_FAST;
                            // equal bits fall back to band one
                            hb2_sel_next = cmd_arg8[RCD_HB2_BIT]
                                && !cmd_arg8[RCD_HB1_BIT];
                            band_select_next = 5'h00;
                        end else begin
                            pass_kind_next = RCD_PASS_ANALYSE;
                            band_select_next = cmd_arg8[4:0];
                        end
                    end else if (!cmd_sub4[3] && cmd_sub_nib == 4'h1) begin
                        pass_start_next = 1'b1;
                        pass_kind_next = RCD_PASS_CAL;
                        band_select_next = cmd_arg8[4:0];
                    end
                end
                RCD_CLS_DEV: begin
                    if (cmd_sub4[3] || cmd_sub_nib[3]) begin
                        // bits 12 and 11 lie outside the table
                    end else if (cmd_sub_nib[2:0] == 3'h1) begin
                        version_next = RCD_FW_VERSION;
                    end
                    // no_operation_cmd, sounder tests and undefined store nothing
                end
                RCD_CLS_INIT: begin
                    if (cmd_sub4[3]) begin
                        // bit 12 set is an undefined subtype
                    end else if (!cmd_sub_nib[3]) begin
                        fpga_word_next[cmd_sub_nib[2:0]] = cmd_arg8;
                    end else begin
                        unique case (cmd_sub_nib[2:0])
                            3'h0: reinit_next = 3'h1;
                            3'h1: reinit_next = 3'h2;
                            3'h2: reinit_next = 3'h4;
                            3'h3: begin
                                if (cmd_arg8[1:0] != 2'h3) begin
                                    synth_sel_next = cmd_arg8[1:0];
                                end
                            end
                            3'h4: begin
                                if (cmd_arg8 == RCD_CMP_NONE) begin
                                    compress_next = 2'h0;
                                end else if (cmd_arg8 == RCD_CMP_MEANDER) begin
                                    compress_next = 2'h1;
                                end else if (cmd_arg8 == RCD_CMP_RICE) begin
                                    compress_next = 2'h2;
                                end
                            end
                            3'h5: mfr_ant_next = cmd_arg8[6:0];
                            3'h6: limit_relay_next = cmd_arg8;
                            3'h7: atten_next = cmd_arg8;
                        endcase
                    end
                end
                RCD_CLS_MODE: begin
                    unique case (cmd_sub4)
                        4'h0: abc_mode_next[7:0] = cmd_arg8;
                        4'h1: abc_mode_next[15:8] = cmd_arg8;
                        4'h2: abc_rep_next = cmd_arg9;
                        4'h3: hb1_start_next = cmd_arg9;
                        4'h4: hb1_step_next = cmd_arg9;
                        4'h5: hb1_count_next = cmd_arg9;
                        4'h6: hb1_mode_next[7:0] = cmd_arg8;
                        4'h7: hb1_mode_next[15:8] = cmd_arg8;
                        4'h8: hb1_rep_next = cmd_arg9;
                        4'h9: hb2_start_next = cmd_arg9;
                        4'hA: hb2_step_next = cmd_arg9;
                        4'hB: hb2_count_next = cmd_arg9;
                        4'hC: hb2_mode_next[7:0] = cmd_arg8;
                        4'hD: hb2_mode_next[15:8] = cmd_arg8;
                        4'hE: hb2_rep_next = cmd_arg9;
                        4'hF: cycle_cnt_next = cmd_arg9;
                    endcase
                end
                RCD_CLS_SND: begin
                    if (cmd_sub4[3]) begin
                        // bit 12 set is an undefined subtype
                    end else if (cmd_sub_nib == 4'h0) begin
                        snd_mode_next = cmd_arg8;
                    end else if (cmd_sub_nib == 4'hE) begin
                        fast_a_next = cmd_arg8;
                    end else if (cmd_sub_nib == 4'hF) begin
                        fast_b_next = cmd_arg8;
                    end
                end
                default: begin
                    // other classes are handled elsewhere; ignored
                end
            endcase
        end
        // software closes a block by writing the block register
        if (wr_en && paddr == RCD_BLK_OFS) begin
            blk_len_next = 8'h00;
            blk_drop_next = 1'b0;
        end
    end

    // read mux, sampled in the setup cycle
    always_comb begin
        prdata_next = 32'h0000_0000;
        if (rd_en) begin
            unique case (paddr)
                RCD_CMD_OFS: prdata_next = {16'h0000, last_cmd_reg};
                RCD_STAT_OFS: prdata_next = {15'h0000, blk_drop_reg,
                    version_reg, 1'b0, synth_sel_reg, compress_reg,
                    1'b0, pass_kind};
                RCD_BAND_OFS: prdata_next = {26'h0000000,
                    high_band_two_sel, band_select};
                RCD_INIT_OFS: prdata_next = {9'h000, mfr_ant_reg,
                    limit_relay_reg, atten_reg};
                RCD_ABC_OFS: prdata_next = {7'h00, abc_rep_reg,
                    abc_mode_reg};
                RCD_HB1_OFS: prdata_next = {hb1_mode_reg[7:0],
                    hb1_count_reg[7:0], hb1_step_reg[7:0],
                    hb1_start_reg[7:0]};
                RCD_HB2_OFS: prdata_next = {hb2_mode_reg[7:0],
                    hb2_count_reg[7:0], hb2_step_reg[7:0],
                    hb2_start_reg[7:0]};
                RCD_SND_OFS: prdata_next = {7'h00, cycle_cnt_reg,
                    hb2_rep_reg[7:0], snd_mode_reg};
                RCD_FAST_OFS: prdata_next = {hb1_rep_reg[7:0],
                    hb2_mode_reg[15:8], fast_b_reg, fast_a_reg};
                RCD_BLK_OFS: prdata_next = {24'h000000, blk_len_reg};
                RCD_FPGA_OFS: prdata_next = {fpga_word_reg[3],
                    fpga_word_reg[2], fpga_word_reg[1], fpga_word_reg[0]};
                default: prdata_next = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            abc_mode_reg <= 16'h0000;
            hb1_mode_reg <= 16'h0000;
            hb2_mode_reg <= 16'h0000;
            abc_rep_reg <= 9'h000;
            hb1_rep_reg <= 9'h000;
            hb2_rep_reg <= 9'h000;
            hb1_start_reg <= 9'h000;
            hb1_step_reg <= 9'h000;
            hb1_count_reg <= 9'h000;
            hb2_start_reg <= 9'h000;
            hb2_step_reg <= 9'h000;
            hb2_count_reg <= 9'h000;
            cycle_cnt_reg <= 9'h000;
            for (int i = 0; i < 8; i++) begin
                fpga_word_reg[i] <= 8'h00;
            end
            synth_sel_reg <= 2'h0;
            compress_reg <= 2'h0;
            mfr_ant_reg <= 7'h00;
            limit_relay_reg <= 8'h00;
            atten_reg <= 8'h00;
            reinit_reg <= 3'h0;
            snd_mode_reg <= 8'h00;
            fast_a_reg <= 8'h00;
            fast_b_reg <= 8'h00;
            version_reg <= 8'h00;
            blk_len_reg <= 8'h00;
            blk_drop_reg <= 1'b0;
            last_cmd_reg <= 16'h0000;
            prdata <= 32'h0000_0000;
            pass_start <= 1'b0;
            pass_kind <= RCD_PASS_NONE;
            band_select <= 5'h00;
            high_band_two_sel <= 1'b0;
        end else begin
            abc_mode_reg <= abc_mode_next;
            hb1_mode_reg <= hb1_mode_next;
            hb2_mode_reg <= hb2_mode_next;
            abc_rep_reg <= abc_rep_next;
            hb1_rep_reg <= hb1_rep_next;
            hb2_rep_reg <= hb2_rep_next;
            hb1_start_reg <= hb1_start_next;
            hb1_step_reg <= hb1_step_next;
            hb1_count_reg <= hb1_count_next;
            hb2_start_reg <= hb2_start_next;
            hb2_step_reg <= hb2_step_next;
            hb2_count_reg <= hb2_count_next;
            cycle_cnt_reg <= cycle_cnt_next;
            fpga_word_reg <= fpga_word_next;
            synth_sel_reg <= synth_sel_next;
            compress_reg <= compress_next;
            mfr_ant_reg <= mfr_ant_next;
            limit_relay_reg <= limit_relay_next;
            atten_reg <= atten_next;
            reinit_reg <= reinit_next;
            snd_mode_reg <= snd_mode_next;
            fast_a_reg <= fast_a_next;
            fast_b_reg <= fast_b_next;
            version_reg <= version_next;
            blk_len_reg <= blk_len_next;
            blk_drop_reg <= blk_drop_next;
            last_cmd_reg <= last_cmd_next;
            if (rd_en) begin
                prdata <= prdata_next;
            end
            pass_start <= pass_start_next;
            pass_kind <= pass_kind_next;
            band_select <= band_select_next;
            high_band_two_sel <= hb2_sel_next;
        end
    end

    // zero wait states; no error is signalled
    assign pready = 1'b1;
    assign pslverr = 1'b0;
endmodule

// >>> common/rcd_pkg.sv
// package of constants for the receiver command decoder
package rcd_pkg;
    // ------------------------------------------------------------
    // apb register map
    // ------------------------------------------------------------
    localparam logic [7:0] RCD_CMD_OFS = 8'h00;
    localparam logic [7:0] RCD_STAT_OFS = 8'h04;
    localparam logic [7:0] RCD_BAND_OFS = 8'h08;
    localparam logic [7:0] RCD_INIT_OFS = 8'h0C;
    localparam logic [7:0] RCD_ABC_OFS = 8'h10;
    localparam logic [7:0] RCD_HB1_OFS = 8'h14;
    localparam logic [7:0] RCD_HB2_OFS = 8'h18;
    localparam logic [7:0] RCD_SND_OFS = 8'h1C;
    localparam logic [7:0] RCD_FAST_OFS = 8'h20;
    localparam logic [7:0] RCD_BLK_OFS = 8'h24;
    localparam logic [7:0] RCD_FPGA_OFS = 8'h28;
    // ------------------------------------------------------------
    // command classes (top three bits)
    // ------------------------------------------------------------
    localparam logic [2:0] RCD_CLS_DEV = 3'h0;
    localparam logic [2:0] RCD_CLS_INIT = 3'h3;
    localparam logic [2:0] RCD_CLS_MODE = 3'h4;
    localparam logic [2:0] RCD_CLS_SND = 3'h5;
    localparam logic [2:0] RCD_CLS_ANAL = 3'h7;
    localparam int RCD_CLS_MSB = 15;
    localparam int RCD_CLS_LSB = 13;
    localparam int RCD_FAST_BIT = 5;
    localparam int RCD_HB2_BIT = 4;
    localparam int RCD_HB1_BIT = 3;
    localparam logic [7:0] RCD_BLK_MAX = 8'h7F;
    localparam logic [7:0] RCD_FW_VERSION = 8'h11; // arbitrary value
    localparam logic [7:0] RCD_CMP_NONE = 8'h00;
    localparam logic [7:0] RCD_CMP_MEANDER = 8'h20;
    localparam logic [7:0] RCD_CMP_RICE = 8'h40;
    localparam logic [15:0] RCD_ZERO16 = 16'h0000;

    // measurement pass kinds
    typedef enum logic [1:0] {
        RCD_PASS_NONE = 2'b00,
        RCD_PASS_ANALYSE = 2'b01,
        RCD_PASS_FAST = 2'b10,
        RCD_PASS_CAL = 2'b11
    } rcd_pass_t;
endpackage

// >>> hw/rcd_field_decode.sv
// combinational split of a command word into class and subtype
`timescale 1ns/10ps
module rcd_field_decode (
    input wire logic [15:0] cmd_word, // command word
    output logic [2:0] cmd_class, // major class
    output logic [3:0] cmd_sub4, // bits 12..9
    output logic [3:0] cmd_sub_nib, // bits 11..8
    output logic [8:0] cmd_arg9, // bits 8..0
    output logic [7:0] cmd_arg8 // bits 7..0
);
    import rcd_pkg::*;
    // ------------------------------------------------------------
    // field split
    // ------------------------------------------------------------
    always_comb begin
        cmd_class = cmd_word[RCD_CLS_MSB:RCD_CLS_LSB];
        cmd_sub4 = cmd_word[12:9];
        cmd_sub_nib = cmd_word[11:8];
        cmd_arg9 = cmd_word[8:0];
        cmd_arg8 = cmd_word[7:0];
    end
endmodule

// >>> bench/rcd_decoder_sva.sv
// assertion checker for the receiver command decoder
`timescale 1ns/10ps
module rcd_decoder_sva (
    input wire logic core_clk, // clock
    input wire logic rst, // reset
    input wire logic psel, // select
    input wire logic penable, // enable
    input wire logic pwrite, // direction
    input wire logic [7:0] paddr, // address
    input wire logic [31:0] pwdata, // write data
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic pass_start, // pass pulse
    input wire rcd_pkg::rcd_pass_t pass_kind, // pass kind
    input wire logic [4:0] band_select, // bands
    input wire logic high_band_two_sel // fast band two
);
    import rcd_pkg::*;
    // ----
    // checks
    // ----
    // only a read setup may reload prdata, so software sees one value
    wire logic rd_setup = psel && !penable && !pwrite;
    wire logic cmd_take = psel && penable && pwrite && paddr == RCD_CMD_OFS;
    wire logic blk_take = psel && penable && pwrite && paddr == RCD_BLK_OFS;
    // helper: block byte count and whether a version query was taken
    logic [7:0] blk_cnt;
    logic blk_full, ver_seen;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            blk_cnt <= 8'h00;
            blk_full <= 1'b0;
            ver_seen <= 1'b0;
        end else if (blk_take) begin
            blk_cnt <= 8'h00;
            blk_full <= 1'b0;
        end else if (cmd_take && !blk_full) begin
            if (blk_cnt > RCD_BLK_MAX - 8'h02) begin
                blk_full <= 1'b1;
            end else begin
                blk_cnt <= blk_cnt + 8'h02;
                ver_seen <= ver_seen || pwdata[15:8] == 8'h01;
            end
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    a_bus_answer: assert property (pready && !pslverr)
        else $error("bus answer not zero wait or error flagged");
    a_start_cause: assert property (pass_start |-> $past(psel &&
        penable && pwrite && paddr == RCD_CMD_OFS &&
        pwdata[15:13] == RCD_CLS_ANAL && pwdata[12:9] == 4'h0))
        else $error("pass start without a pass command");
    a_kind_pick: assert property (pass_start |-> pass_kind ==
        ($past(pwdata[8]) ? RCD_PASS_CAL : $past(pwdata[5]) ?
        RCD_PASS_FAST : RCD_PASS_ANALYSE)) else $error("wrong pass kind");
    a_band_copy: assert property (pass_start &&
        pass_kind != RCD_PASS_FAST |-> band_select == $past(pwdata[4:0]))
        else $error("band set differs from command");
    a_fast_band: assert property (pass_start &&
        pass_kind == RCD_PASS_FAST |-> band_select == 5'h00 &&
        high_band_two_sel == ($past(pwdata[4]) && !$past(pwdata[3])))
        else $error("fast pass band choice wrong");
    a_start_pulse: assert property (pass_start |=> !pass_start)
        else $error("pass start longer than one cycle");
    a_pass_hold: assert property (!pass_start |->
        $stable(pass_kind) && $stable(band_select) &&
        $stable(high_band_two_sel))
        else $error("pass settings moved without a pass");
    a_version_read: assert property (rd_setup &&
        paddr == RCD_STAT_OFS |=> prdata[15:8] ==
        (ver_seen ? RCD_FW_VERSION : 8'h00))
        else $error("version field wrong");
    a_drop_flag: assert property (rd_setup &&
        paddr == RCD_STAT_OFS |=> prdata[16] == blk_full)
        else $error("block drop flag wrong");
    a_unmapped_zero: assert property (rd_setup && paddr >= 8'h80 |=>
        prdata == 32'h00000000) else $error("unmapped read not zero");
    a_prdata_hold: assert property (!rd_setup |=> $stable(prdata))
        else $error("read data moved outside a read setup");
endmodule
bind rcd_decoder rcd_decoder_sva u_sva (.core_clk(core_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pass_start(pass_start), .pass_kind(pass_kind),
    .band_select(band_select), .high_band_two_sel(high_band_two_sel));

// >>> bench/rcd_host_model.sv
// host model that issues command words over the register bus
`timescale 1ns/10ps
module rcd_host_model (
    input wire logic core_clk, // clock
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    output logic psel, // select
    output logic penable, // enable
    output logic pwrite, // direction
    output logic [7:0] paddr, // address
    output logic [31:0] pwdata // write data
);
    // ----
    // bus master
    // ----
    // idle bus from time zero
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    // one transfer; the request is held until pready is seen high
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        q = prdata;
        // released lines show the inverse so stale values cannot pass
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// >>> bench/rcd_decoder_bench.sv
// self-checking bench for the receiver command decoder
`timescale 1ns/10ps
module rcd_decoder_bench;
    import rcd_pkg::*;
    logic core_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic pass_start, high_band_two_sel;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    rcd_pass_t pass_kind;
    logic [4:0] band_select;
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;
    rcd_decoder u_dut (.core_clk(core_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pass_start(pass_start), .pass_kind(pass_kind),
        .band_select(band_select), .high_band_two_sel(high_band_two_sel));
    rcd_host_model u_host (.core_clk(core_clk), .prdata(prdata),
        .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));
    // ----
    // clock, timeout and verdict
    // ----
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // the whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail = n_fail + 1;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ----
    // compare and drive helpers
    // ----
    task automatic chk_pass(input logic s, input logic [1:0] k,
                            input logic [4:0] b);
        tests_run++;
        if ({pass_start, pass_kind, band_select} !== {s, k, b}) begin
            n_fail++;
            $display("MISMATCH %0t pass outputs %b %b %b", $time,
                     pass_start, pass_kind, band_select);
        end
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t value %h want %h", $time, got, exp);
        end
    endtask
    // command write; outputs are looked at once the edge has landed
    task automatic send(input logic [15:0] c);
        u_host.xfer(1'b1, RCD_CMD_OFS, {16'h0000, c}, rd);
        #1;
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_passes();
        logic [15:0] w[10] = '{16'hE01F, 16'hE018, 16'hE01C, 16'hE007,
            16'hE010, 16'hE020, 16'hE028, 16'hE030, 16'hE038, 16'hE11F};
        foreach (w[i]) begin
            send(w[i]);
            if (w[i][8])
                chk_pass(1'b1, 2'h3, w[i][4:0]);
            else if (w[i][5]) begin
                chk_pass(1'b1, 2'h2, 5'h00);
                chk_val(high_band_two_sel, w[i][4] & ~w[i][3]);
            end else
                chk_pass(1'b1, 2'h1, w[i][4:0]);
        end
    endtask
    // dev words and undefined subtypes leave the last pass alone
    task automatic t_quiet();
        send(16'hE102);
        send(16'h0000);
        chk_pass(1'b0, 2'h3, 5'h02);
        send(16'h0100);
        send(16'h0700);
        chk_pass(1'b0, 2'h3, 5'h02);
        send(16'hE200);
        chk_pass(1'b0, 2'h3, 5'h02);
        u_host.xfer(1'b0, RCD_STAT_OFS, 32'h00000000, rd);
        chk_val(rd[15:8], RCD_FW_VERSION);
        chk_val(rd[1:0], RCD_PASS_CAL);
        u_host.xfer(1'b0, 8'h80, 32'h00000000, rd);
        chk_val(rd, 32'h0000_0000);
    endtask
    // setup classes land in their read fields; bit 12 set is undefined
    task automatic t_setup();
        send(16'h6D5B);
        send(16'h6E3C);
        send(16'h6FA5);
        send(16'h7D00);
        u_host.xfer(1'b0, RCD_INIT_OFS, 32'h00000000, rd);
        chk_val(rd, 32'h005B_3CA5);
        send(16'h6B02);
        send(16'h6B03);
        send(16'h6C20);
        send(16'h6C33);
        u_host.xfer(1'b0, RCD_STAT_OFS, 32'h00000000, rd);
        chk_val(rd[6:0], 7'h49);
        send(16'h8155);
        send(16'h8233);
        send(16'h8507);
        u_host.xfer(1'b0, RCD_ABC_OFS, 32'h00000000, rd);
        chk_val(rd, 32'h0107_3355);
        send(16'h8612);
        send(16'h8804);
        u_host.xfer(1'b0, RCD_HB1_OFS, 32'h00000000, rd);
        chk_val(rd, 32'h0000_0412);
        send(16'h9E09);
        send(16'hA07E);
        send(16'hB0FF);
        u_host.xfer(1'b0, RCD_SND_OFS, 32'h00000000, rd);
        chk_val(rd, 32'h0009_007E);
        send(16'hAE11);
        send(16'hAF22);
        u_host.xfer(1'b0, RCD_FAST_OFS, 32'h00000000, rd);
        chk_val(rd, 32'h0000_2211);
    endtask
    // fill a block to 126 bytes, then overrun it on purpose
    task automatic t_block();
        u_host.xfer(1'b1, RCD_BLK_OFS, 32'h00000000, rd);
        repeat (62) send(16'h0000);
        send(16'hE001);
        chk_pass(1'b1, 2'h1, 5'h01);
        send(16'hE002);
        chk_pass(1'b0, 2'h1, 5'h01);
        u_host.xfer(1'b0, RCD_STAT_OFS, 32'h00000000, rd);
        chk_val(rd[16], 1'b1);
        u_host.xfer(1'b1, RCD_BLK_OFS, 32'h00000000, rd);
        send(16'hE004);
        chk_pass(1'b1, 2'h1, 5'h04);
        u_host.xfer(1'b0, RCD_STAT_OFS, 32'h00000000, rd);
        chk_val(rd[16], 1'b0);
    endtask
    initial begin
        rst = 1'b1;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        t_passes();
        t_quiet();
        t_block();
        t_setup();
        report_and_stop();
    end
endmodule
